/* File: rtl/ftm_top.sv */
// Fan tachometer period measurement: four speed sense channels.
// Assumes drive outputs come from on-chip logic on the same clock and
// speed sense pins are asynchronous.
`timescale 1ns/1ps
module ftm_top #(
	parameter int CNT_W = 16,
	parameter int TICK_DIV = ftm_pkg::TIMEBASE_CYCLES
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rd_data,
	// Fan drive outputs, same clock
	input wire logic fan_drive_1,
	input wire logic fan_drive_2,
	input wire logic fan_drive_3,
	// Tachometer pins
	input wire logic speed_sense_1,
	input wire logic speed_sense_2,
	input wire logic speed_sense_3,
	input wire logic speed_sense_4
);

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	logic [7:0] acoustic_one_q, acoustic_one_d;
	logic [7:0] ppr_q, ppr_d;
	logic [7:0] two_wire_q, two_wire_d;
	logic [7:0] drive_cfg_q, drive_cfg_d;

	always_comb begin
		acoustic_one_d = acoustic_one_q;
		ppr_d = ppr_q;
		two_wire_d = two_wire_q;
		drive_cfg_d = drive_cfg_q;
		if (wr_en) begin
			case (addr)
				ftm_pkg::ADDR_ACOUSTIC_ONE: acoustic_one_d = wr_data;
				ftm_pkg::ADDR_PPR: ppr_d = wr_data; // R7
				ftm_pkg::ADDR_TWO_WIRE_CFG: two_wire_d = {4'h0, wr_data[3:0]};
				ftm_pkg::ADDR_DRIVE_CFG: drive_cfg_d = wr_data; // R8
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			acoustic_one_q <= ftm_pkg::ACOUSTIC_ONE_RESET;
			ppr_q <= ftm_pkg::PPR_RESET;
			two_wire_q <= ftm_pkg::TWO_WIRE_CFG_RESET;
			drive_cfg_q <= ftm_pkg::DRIVE_CFG_RESET;
		end else begin
			acoustic_one_q <= acoustic_one_d;
			ppr_q <= ppr_d;
			two_wire_q <= two_wire_d;
			drive_cfg_q <= drive_cfg_d;
		end
	end

	// ----------------------------------------------------------------
	// Pin synchronisers and edge detect
	// ----------------------------------------------------------------
	logic [3:0] sense_meta_q, sense_sync_q, sense_prev_q;
	logic [3:0] sense_rise;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			// Pins idle high behind pull-ups; a low reset would fake a rise
			sense_meta_q <= 4'hf;
			sense_sync_q <= 4'hf;
			sense_prev_q <= 4'hf;
		end else begin
			sense_meta_q <= {speed_sense_4, speed_sense_3, speed_sense_2, speed_sense_1};
			sense_sync_q <= sense_meta_q;
			sense_prev_q <= sense_sync_q;
		end
	end

	assign sense_rise = sense_sync_q & ~sense_prev_q;

	// ----------------------------------------------------------------
	// Drive timing select and channel gating
	// ----------------------------------------------------------------
	logic low_freq;
	logic shared_drive;
	logic [3:0] timed_drive;
	logic [3:0] chan_active;

	// Code 00 counts one period, so the window needs code plus one more edge
	function automatic logic [2:0] edges_for(input logic [1:0] code);
		edges_for = {1'b0, code} + 3'h1; // R9
	endfunction

	assign low_freq = drive_cfg_q[ftm_pkg::LOW_FREQ_BIT]; // R8
	assign shared_drive = acoustic_one_q[ftm_pkg::SHARED_DRIVE_BIT];

	always_comb begin
		timed_drive[0] = fan_drive_1; // R1
		timed_drive[1] = shared_drive ? fan_drive_3 : fan_drive_2; // R3
		timed_drive[2] = fan_drive_3; // R2
		timed_drive[3] = fan_drive_3; // R2
		for (int i = 0; i < 4; i++) begin
			if (!low_freq) begin
				// Continuously powered fans: tach is valid at any time
				chan_active[i] = !two_wire_q[i]; // R4 R5
			end else begin
				chan_active[i] = timed_drive[i];
			end
		end
	end

	// ----------------------------------------------------------------
	// Timebase and period counters
	// ----------------------------------------------------------------
	logic tick;
	logic [CNT_W-1:0] result [4];

	ftm_timebase #(
		.DIV(TICK_DIV)
	) u_timebase (
		.clock(clock),
		.rst_n(rst_n),
		.tick(tick)
	);

	for (genvar g = 0; g < 4; g++) begin : g_chan
		ftm_tach_chan #(
			.CNT_W(CNT_W)
		) u_chan (
			.clock(clock),
			.rst_n(rst_n),
			.tick(tick),
			.tach_rise(sense_rise[g]),
			.active(chan_active[g]),
			.edges_needed(edges_for(ppr_q[2*g +: 2])), // R7
			.result(result[g])
		);
	end

	// ----------------------------------------------------------------
	// Result read with high byte freeze
	// ----------------------------------------------------------------
	// Low byte read snapshots the high byte so a count rolling over
	// between the two reads cannot tear the value.
	logic [3:0] frozen_q, frozen_d;
	logic [7:0] hold_q [4];
	logic [7:0] hold_d [4];
	logic [7:0] rd_data_q, rd_data_d;
	logic res_hit;
	logic [1:0] res_chan;
	logic res_high;

	assign res_hit = addr >= ftm_pkg::ADDR_RESULT_BASE && addr <= ftm_pkg::ADDR_RESULT_LAST;
	assign res_chan = 2'((addr - ftm_pkg::ADDR_RESULT_BASE) >> 1);
	assign res_high = addr[0];

	always_comb begin
		frozen_d = frozen_q;
		hold_d = hold_q;
		rd_data_d = 8'h00;
		if (rd_en) begin
			if (res_hit) begin
				if (!res_high) begin
					rd_data_d = result[res_chan][7:0];
					hold_d[res_chan] = result[res_chan][15:8]; // R11
					frozen_d[res_chan] = 1'b1;
				end else begin
					rd_data_d = frozen_q[res_chan] ? hold_q[res_chan]
						: result[res_chan][15:8]; // R11
					frozen_d[res_chan] = 1'b0;
				end
			end else begin
				case (addr)
					ftm_pkg::ADDR_ACOUSTIC_ONE: rd_data_d = acoustic_one_q;
					ftm_pkg::ADDR_PPR: rd_data_d = ppr_q;
					ftm_pkg::ADDR_TWO_WIRE_CFG: rd_data_d = two_wire_q;
					ftm_pkg::ADDR_DRIVE_CFG: rd_data_d = drive_cfg_q;
					default: rd_data_d = 8'h00;
				endcase
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			frozen_q <= 4'h0;
			for (int i = 0; i < 4; i++) begin
				hold_q[i] <= 8'h00;
			end
			rd_data_q <= 8'h00;
		end else begin
			frozen_q <= frozen_d;
			hold_q <= hold_d;
			rd_data_q <= rd_data_d;
		end
	end

	assign rd_data = rd_data_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	acoustic_write_a: assert property (wr_en && addr == ftm_pkg::ADDR_ACOUSTIC_ONE // R3
			|=> acoustic_one_q == $past(wr_data))
		else $error("shared-drive register write lost");

	ppr_write_a: assert property (wr_en && addr == ftm_pkg::ADDR_PPR // R7
			|=> ppr_q == $past(wr_data))
		else $error("pulse count write lost");

	drive_write_a: assert property (wr_en && addr == ftm_pkg::ADDR_DRIVE_CFG // R8
			|=> drive_cfg_q == $past(wr_data))
		else $error("drive mode write lost");

	two_wire_write_a: assert property (wr_en && addr == ftm_pkg::ADDR_TWO_WIRE_CFG // R5
			|=> two_wire_q == {4'h0, $past(wr_data[3:0])})
		else $error("two-wire write wrong");

	ppr_hold_a: assert property (!wr_en |=> $stable(ppr_q)) // R7
		else $error("pulse count changed without a write");

	// ----------------------------------------------------------------
	// Register reads and result freeze
	// ----------------------------------------------------------------
	freeze_high_a: assert property (rd_en && res_hit && !res_high ##1 rd_en && res_hit // R11
			&& res_high && res_chan == $past(res_chan)
			|=> rd_data == $past(result[res_chan], 2) >> 8)
		else $error("high byte not frozen");

	ppr_read_a: assert property (wr_en && addr == ftm_pkg::ADDR_PPR ##1 rd_en // R7
			&& addr == ftm_pkg::ADDR_PPR |=> rd_data == $past(wr_data, 2))
		else $error("pulse count field lost");

	low_read_a: assert property (rd_en && res_hit && !res_high // R11
			|=> rd_data == $past(result[res_chan][7:0]))
		else $error("low byte read wrong");

	high_live_a: assert property (rd_en && res_hit && res_high && !frozen_q[res_chan] // R11
			|=> rd_data == $past(result[res_chan][15:8]))
		else $error("live high byte read wrong");

	freeze_set_a: assert property (rd_en && res_hit && !res_high // R11
			|=> frozen_q[$past(res_chan)])
		else $error("low byte read did not freeze");

	freeze_clear_a: assert property (rd_en && res_hit && res_high // R11
			|=> !frozen_q[$past(res_chan)])
		else $error("high byte read did not release");

	freeze_keep_a: assert property (!rd_en |=> $stable(frozen_q)) // R11
		else $error("freeze changed without a read");

	drive_read_a: assert property (rd_en && addr == ftm_pkg::ADDR_DRIVE_CFG // R8
			|=> rd_data == $past(drive_cfg_q))
		else $error("drive mode read wrong");

	acoustic_read_a: assert property (rd_en && addr == ftm_pkg::ADDR_ACOUSTIC_ONE // R3
			|=> rd_data == $past(acoustic_one_q))
		else $error("shared-drive register read wrong");

	read_idle_a: assert property (!rd_en |=> rd_data == 8'h00)
		else $error("read data outside read slot");

	// ----------------------------------------------------------------
	// Channel gating
	// ----------------------------------------------------------------
	shared_sel_a: assert property (low_freq && shared_drive && !fan_drive_3 // R3
			|-> !chan_active[1] && !chan_active[2] && !chan_active[3])
		else $error("shared drive not applied");

	shared_follow_a: assert property (low_freq && shared_drive // R3
			|-> chan_active[1] == fan_drive_3)
		else $error("sense 2 not timed to drive 3");

	own_drive_a: assert property (low_freq && !shared_drive // R1
			|-> chan_active[1] == fan_drive_2
			&& chan_active[0] == fan_drive_1 && chan_active[3] == fan_drive_3)
		else $error("channel timed to wrong drive");

	drive3_pair_a: assert property (low_freq // R2
			|-> chan_active[2] == fan_drive_3 && chan_active[3] == fan_drive_3)
		else $error("senses 3 and 4 not timed to drive 3");

	hf_active_a: assert property (!low_freq |-> chan_active == ~two_wire_q[3:0]) // R4
		else $error("high mode gating wrong");

	two_wire_a: assert property (!low_freq && two_wire_q[0] |-> !chan_active[0]) // R5
		else $error("two-wire fan measured in high mode");

endmodule

/* File: rtl/ftm_pkg.sv */
// Constants shared by the fan tachometer period measurement block.
// Assumes one 250 MHz clock and an 8-bit register port with 8-bit addresses.
// Operation
// R1 - Speed sense 1 measurements are timed to fan drive output 1.
// R2 - Speed sense 3 and 4 measurements are timed to fan drive output 3.
// R3 - Shared-drive bit 4 of 0x62 times senses 2, 3 and 4 to drive 3.
// R4 - High frequency drive mode needs no timing to a drive output.
// R5 - Two-wire fans are measured only in low frequency drive mode.
// R6 - A 90 kHz timebase feeds a 16-bit counter for N tach periods.
// R7 - N comes from a two-bit field per fan in 0x7B, default two.
// R8 - Drive frequency is either a low frequency set or one high frequency.
// R9 - Field codes 00, 01, 10, 11 mean one, two, three, four pulses.
// R10 - Counting runs from the first tach rising edge to the (N+1)th.
// R11 - Reading the low byte freezes the high byte until it is read.
// R12 - A result of 0xFFFF marks a stalled or very slow fan.
// R13 - The period counter saturates at all ones instead of wrapping.
package ftm_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_RESULT_BASE = 8'h28;
	localparam logic [7:0] ADDR_RESULT_LAST = 8'h2f;
	localparam logic [7:0] ADDR_ACOUSTIC_ONE = 8'h62;
	localparam logic [7:0] ADDR_TWO_WIRE_CFG = 8'h73;
	localparam logic [7:0] ADDR_DRIVE_CFG = 8'h7c;
	localparam logic [7:0] ADDR_PPR = 8'h7b;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int SHARED_DRIVE_BIT = 4;
	localparam int LOW_FREQ_BIT = 2;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] ACOUSTIC_ONE_RESET = 8'h00;
	localparam logic [7:0] PPR_RESET = 8'h55;
	localparam logic [7:0] TWO_WIRE_CFG_RESET = 8'h00;
	localparam logic [7:0] DRIVE_CFG_RESET = 8'h00;
	localparam logic [15:0] RESULT_RESET = 16'h0000;
	localparam logic [15:0] RESULT_STALL = 16'hffff;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLOCK_PERIOD_NS = 4;
	localparam int TIMEBASE_PERIOD_NS = 11110;
	localparam int TIMEBASE_CYCLES = TIMEBASE_PERIOD_NS / CLOCK_PERIOD_NS;

	typedef enum logic [0:0] {
		ST_WAIT = 1'b0,
		ST_COUNT = 1'b1
	} ftm_state_e;

endpackage

/* File: rtl/ftm_timebase.sv */
// Timebase divider for the fan period counters.
// Assumes the system clock; emits a one-cycle tick each timebase period.
`timescale 1ns/1ps
module ftm_timebase #(
	parameter int DIV = ftm_pkg::TIMEBASE_CYCLES
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Tick out
	output logic tick
);

	logic [11:0] div_q, div_d;
	logic tick_q, tick_d;

	always_comb begin
		div_d = div_q + 12'h001;
		tick_d = 1'b0;
		if (div_q == 12'(DIV - 1)) begin
			div_d = 12'h000;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			div_q <= 12'h000;
			tick_q <= 1'b0;
		end else begin
			div_q <= div_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;

	// Cycles since the last tick, for the period checks only; a counter
	// rather than a delay, since the real divider is far too long to unroll
	logic [11:0] gap_q, gap_d;
	logic seen_q, seen_d;

	always_comb begin
		gap_d = tick_q ? 12'h000 : gap_q + 12'h001;
		seen_d = seen_q | tick_q;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			gap_q <= 12'h000;
			seen_q <= 1'b0;
		end else begin
			gap_q <= gap_d;
			seen_q <= seen_d;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	tick_spacing_a: assert property (seen_q && !tick |-> gap_q < 12'(DIV - 1)) // R6
		else $error("timebase tick missed");
	tick_period_a: assert property (seen_q && tick |-> gap_q == 12'(DIV - 1)) // R6
		else $error("timebase period wrong");

endmodule

/* File: rtl/ftm_tach_chan.sv */
// One fan period counter channel.
// Assumes tach_rise is a synchronised one-cycle edge and tick the timebase.
`timescale 1ns/1ps
module ftm_tach_chan #(
	parameter int CNT_W = 16
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Timing inputs
	input wire logic tick,
	input wire logic tach_rise,
	input wire logic active,
	input wire logic [2:0] edges_needed,
	// Result
	output logic [CNT_W-1:0] result
);

	localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

	ftm_pkg::ftm_state_e st_q, st_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [CNT_W-1:0] res_q, res_d;
	logic [2:0] edg_q, edg_d;

	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		res_d = res_q;
		edg_d = edg_q;
		if (!active) begin
			// Drive off: nothing valid to measure, restart cleanly later
			st_d = ftm_pkg::ST_WAIT;
			cnt_d = '0;
		end else begin
			case (st_q)
				ftm_pkg::ST_WAIT: begin
					if (tach_rise) begin // R10
						st_d = ftm_pkg::ST_COUNT;
						cnt_d = '0;
						edg_d = edges_needed;
					end
				end
				ftm_pkg::ST_COUNT: begin
					if (tach_rise && edg_q == 3'h1) begin // R10
						// Closing edge opens the next window back to back
						res_d = cnt_q;
						cnt_d = '0;
						edg_d = edges_needed;
					end else if (cnt_q == CNT_MAX) begin
						res_d = CNT_MAX; // R12
						st_d = ftm_pkg::ST_WAIT;
						cnt_d = '0;
					end else begin
						if (tach_rise) begin
							edg_d = edg_q - 3'h1;
						end
						if (tick) begin
							cnt_d = cnt_q + 1'b1; // R6 R13
						end
					end
				end
				default: begin
					st_d = ftm_pkg::ST_WAIT;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st_q <= ftm_pkg::ST_WAIT;
			cnt_q <= '0;
			res_q <= '0;
			edg_q <= 3'h2;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			res_q <= res_d;
			edg_q <= edg_d;
		end
	end

	assign result = res_q;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	count_tick_a: assert property (active && st_q == ftm_pkg::ST_COUNT && tick // R6
			&& !tach_rise && cnt_q != CNT_MAX |=> cnt_q == $past(cnt_q) + 1'b1)
		else $error("counter missed a timebase tick");
	no_wrap_a: assert property (cnt_q == CNT_MAX && active // R13
			|=> cnt_q == '0 && st_q == ftm_pkg::ST_WAIT || res_q == $past(cnt_q))
		else $error("counter wrapped");
	stall_result_a: assert property (active && st_q == ftm_pkg::ST_COUNT // R12
			&& cnt_q == CNT_MAX && !(tach_rise && edg_q == 3'h1) |=> res_q == CNT_MAX)
		else $error("stall not reported");
	window_close_a: assert property (active && st_q == ftm_pkg::ST_COUNT && tach_rise // R10
			&& edg_q == 3'h1 |=> res_q == $past(cnt_q) && cnt_q == '0)
		else $error("window closed wrong");
	window_open_a: assert property (active && st_q == ftm_pkg::ST_WAIT && tach_rise // R7
			|=> st_q == ftm_pkg::ST_COUNT && edg_q == $past(edges_needed))
		else $error("window opened wrong");

endmodule

/* File: test/ftm_fan_model.sv */
// Fan model: four tachometer outputs, open drain behind pull-ups.
// Assumes the bench clock; a stopped fan leaves its line at the pull-up level.
`timescale 1ns/1ps
module ftm_fan_model (
	// Clock
	input wire logic clock,
	// Control from the bench
	input wire logic [3:0] spin,
	input wire logic [15:0] half_period,
	// Tachometer lines
	output logic [3:0] tach
);

	// ----------------------------------------------------------------
	// Square wave per fan
	// ----------------------------------------------------------------
	for (genvar i = 0; i < 4; i++) begin : g_fan
		logic [15:0] cnt_q = 16'h0000;
		logic lvl_q = 1'b1;
		always_ff @(posedge clock) begin
			if (!spin[i] || cnt_q >= half_period - 16'h0001) begin
				cnt_q <= 16'h0000;
			end else begin
				cnt_q <= cnt_q + 16'h0001;
			end
			// Pull-up holds a stopped fan high, so no stray edge
			if (!spin[i]) begin
				lvl_q <= 1'b1;
			end else if (cnt_q >= half_period - 16'h0001) begin
				lvl_q <= ~lvl_q;
			end
		end
		assign tach[i] = lvl_q;
	end

endmodule

/* File: test/testbench.sv */
// Self-checking bench for the fan period measurement block.
// Assumes a timebase divider of 1, so counts equal clock cycles.
`timescale 1ns/1ps
module testbench;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wr_data = 8'h00;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [7:0] rd_data;
	logic [2:0] drive = 3'h0;
	logic [3:0] spin = 4'h0;
	logic [15:0] half_period = 16'h0064;
	logic [3:0] tach;
	int num_errors = 0;
	int check_count = 0;

	ftm_top #(.TICK_DIV(1)) ftm_top_inst (.clock(clock), .rst_n(rst_n), .addr(addr),
		.wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
		.fan_drive_1(drive[0]), .fan_drive_2(drive[1]), .fan_drive_3(drive[2]),
		.speed_sense_1(tach[0]), .speed_sense_2(tach[1]), .speed_sense_3(tach[2]),
		.speed_sense_4(tach[3]));

	ftm_fan_model ftm_fan_model_inst (.clock(clock), .spin(spin),
		.half_period(half_period), .tach(tach));

	initial begin
		forever #2 clock = ~clock;
	end

	// ----------------------------------------------------------------
	// Checking and bus tasks
	// ----------------------------------------------------------------
	task automatic final_report();
		$display("errors %0d, checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic fail(input string msg);
		num_errors++;
		$display("mismatch at %0t: %s", $time, msg);
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
		check_count++;
		if (got !== exp) fail($sformatf("%s got %h exp %h", msg, got, exp));
	endtask

	// Two counts of slack for where the window edges fall
	task automatic chk_near(input logic [15:0] got, input int exp, input string msg);
		check_count++;
		if (((got + 2 >= exp) && (got <= exp + 2)) !== 1'b1)
			fail($sformatf("%s got %0d exp %0d", msg, got, exp));
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clock);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clock);
		wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clock);
		rd_en <= 1'b0;
		#1;
		d = rd_data;
	endtask

	// Two reads on back-to-back strobes
	task automatic rd2(input logic [7:0] a0, input logic [7:0] a1, output logic [7:0] d0,
			output logic [7:0] d1);
		@(posedge clock);
		addr <= a0;
		rd_en <= 1'b1;
		@(posedge clock);
		addr <= a1;
		#1;
		d0 = rd_data;
		@(posedge clock);
		rd_en <= 1'b0;
		#1;
		d1 = rd_data;
	endtask

	// Write, then read the same address on the very next strobe
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge clock);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clock);
		wr_en <= 1'b0;
		rd_en <= 1'b1;
		@(posedge clock);
		rd_en <= 1'b0;
		#1;
		q = rd_data;
	endtask

	task automatic chk_fans(input int e1, input int e2, input int e3, input int e4);
		logic [7:0] lo;
		logic [7:0] hi;
		int e [4];
		e = '{e1, e2, e3, e4};
		for (int n = 0; n < 4; n++) begin
			rd2(8'h28 + 8'(2 * n), 8'h29 + 8'(2 * n), lo, hi);
			chk_near({hi, lo}, e[n], $sformatf("fan %0d count", n + 1));
		end
	endtask

	task automatic set_fans(input logic [2:0] drv, input logic [15:0] half);
		@(posedge clock);
		drive <= drv;
		half_period <= half;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		logic [7:0] d;
		logic [7:0] a [7] = '{8'h7b, 8'h62, 8'h7c, 8'h73, 8'h28, 8'h2f, 8'h40};
		logic [7:0] e [7] = '{8'h55, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		for (int i = 0; i < 7; i++) begin
			rd(a[i], d);
			chk8(d, e[i], "reset value");
		end
		wr(8'h28, 8'hff);
		wr(8'h40, 8'hff);
		wr(8'h73, 8'hff);
		rd(8'h28, d);
		chk8(d, 8'h00, "result is read only");
		rd(8'h40, d);
		chk8(d, 8'h00, "unmapped read");
		rd(8'h73, d);
		chk8(d, 8'h0f, "two-wire bits");
		wr(8'h73, 8'h00);
	endtask

	// Fan 1 takes code c, fan 4 the mirror code, fans 2 and 3 stay at two
	task automatic t_codes();
		logic [7:0] d;
		logic [7:0] f;
		set_fans(3'h0, 16'h0064);
		for (int c = 0; c < 4; c++) begin
			f = {2'(3 - c), 2'h1, 2'h1, 2'(c)};
			wr_rd(8'h7b, f, d);
			chk8(d, f, "pulse field readback");
			wait_cyc(1800);
			chk_fans(200 * (c + 1), 400, 400, 200 * (4 - c));
		end
		wr(8'h7b, 8'h55);
	endtask

	task automatic t_freeze();
		logic [7:0] d;
		set_fans(3'h0, 16'h012c);
		wait_cyc(3000);
		rd(8'h28, d);
		set_fans(3'h0, 16'h0258);
		wait_cyc(6000);
		rd(8'h29, d);
		chk8(d, 8'h04, "frozen high byte");
		rd(8'h29, d);
		chk8(d, 8'h09, "live high byte");
	endtask

	task automatic t_drive_timing();
		wr(8'h7c, 8'h04);
		wr(8'h62, 8'h10);
		set_fans(3'b011, 16'h0064);
		wait_cyc(1500);
		chk_fans(400, 2400, 2400, 2400);
		set_fans(3'b100, 16'h0096);
		wait_cyc(2000);
		chk_fans(400, 600, 600, 600);
		wr(8'h62, 8'h00);
		set_fans(3'b010, 16'h0064);
		wait_cyc(1500);
		chk_fans(400, 400, 600, 600);
		wr(8'h7c, 8'h00);
		wr(8'h73, 8'h01);
		set_fans(3'b010, 16'h0096);
		wait_cyc(2000);
		chk_fans(400, 600, 600, 600);
		wr(8'h7c, 8'h04);
		set_fans(3'b001, 16'h0096);
		wait_cyc(1500);
		chk_fans(600, 600, 600, 600);
		wr(8'h73, 8'h00);
		wr(8'h7c, 8'h00);
	endtask

	task automatic t_stall();
		@(posedge clock);
		spin <= 4'h0;
		wait_cyc(67000);
		chk_fans(65535, 65535, 65535, 65535);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		wait_cyc(12);
		rst_n <= 1'b1;
		wait_cyc(2);
		t_reset();
		spin <= 4'hf;
		t_codes();
		t_freeze();
		t_drive_timing();
		t_stall();
		final_report();
	end

endmodule
